// ===== design/host_port_pkg.sv
package host_port_pkg;

    // Clock and device reset timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int RST_MIN_NS = 100;
    localparam int RST_MIN_CYC =
        (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Widths and depths
    localparam int ADDR_W = 8;
    localparam int BYTE_W = 8;
    localparam int DATA_W = 16;
    localparam int MEM_DEPTH = 256;
    localparam int STREAMS = 16;
    localparam int IDX_W = 11;
    localparam int SLOT_W = 7;
    localparam int RCNT_W = 2;

    // Control word fields
    localparam int CCO_LSB = 0;
    localparam int HIZ_LSB = 8;

    // Rate codes {high bit, low bit}
    localparam logic [1:0] RATE_2M = 2'h0;
    localparam logic [1:0] RATE_4M = 2'h1;
    localparam logic [1:0] RATE_8M = 2'h2;

    // Last slot of a frame per rate, and last stream of a slot
    localparam logic [SLOT_W-1:0] LAST_SLOT_2M = 7'h1f;
    localparam logic [SLOT_W-1:0] LAST_SLOT_4M = 7'h3f;
    localparam logic [SLOT_W-1:0] LAST_SLOT_8M = 7'h7f;
    localparam logic [3:0] LAST_STREAM = 4'hf;

    typedef enum logic [3:0] {
        TAP_TLR, TAP_RTI, TAP_SDR, TAP_CDR, TAP_SHD, TAP_E1D, TAP_PSD,
        TAP_E2D, TAP_UPD, TAP_SIR, TAP_CIR, TAP_SHI, TAP_E1I, TAP_PSI,
        TAP_E2I, TAP_UPI
    } tap_state_t;

    typedef enum logic [1:0] {
        ACC_IDLE, ACC_ACK, ACC_HIGH
    } acc_state_t;

endpackage

// ===== design/tap_if.sv
interface tap_if;
    logic tck_rise;
    logic tms;
    logic in_reset;
    modport ctrl (input tck_rise, input tms, output in_reset);
    modport user (output tck_rise, output tms, input in_reset);
endinterface

// ===== design/sync2.sv
module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ===== design/tap_ctrl.sv
module tap_ctrl
    import host_port_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic test_rst_n,
    tap_if.ctrl t
);
    tap_state_t st_q;
    tap_state_t st_d;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            TAP_TLR: st_d = t.tms ? TAP_TLR : TAP_RTI;
            TAP_RTI: st_d = t.tms ? TAP_SDR : TAP_RTI;
            TAP_SDR: st_d = t.tms ? TAP_SIR : TAP_CDR;
            TAP_CDR: st_d = t.tms ? TAP_E1D : TAP_SHD;
            TAP_SHD: st_d = t.tms ? TAP_E1D : TAP_SHD;
            TAP_E1D: st_d = t.tms ? TAP_UPD : TAP_PSD;
            TAP_PSD: st_d = t.tms ? TAP_E2D : TAP_PSD;
            TAP_E2D: st_d = t.tms ? TAP_UPD : TAP_SHD;
            TAP_UPD: st_d = t.tms ? TAP_SDR : TAP_RTI;
            TAP_SIR: st_d = t.tms ? TAP_TLR : TAP_CIR;
            TAP_CIR: st_d = t.tms ? TAP_E1I : TAP_SHI;
            TAP_SHI: st_d = t.tms ? TAP_E1I : TAP_SHI;
            TAP_E1I: st_d = t.tms ? TAP_UPI : TAP_PSI;
            TAP_PSI: st_d = t.tms ? TAP_E2I : TAP_PSI;
            TAP_E2I: st_d = t.tms ? TAP_UPI : TAP_SHI;
            TAP_UPI: st_d = t.tms ? TAP_SDR : TAP_RTI;
            default: st_d = TAP_TLR;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst or negedge test_rst_n)
    begin
        if (sys_rst || !test_rst_n)
        begin
            st_q <= TAP_TLR;
            t.in_reset <= 1'b1;
        end
        else if (t.tck_rise)
        begin
            st_q <= st_d;
            t.in_reset <= (st_d == TAP_TLR);
        end
    end
endmodule

// ===== design/host_port_ctrl.sv
module host_port_ctrl
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic dev_rst_n,
    input wire logic test_rst_n,
    input wire logic test_clk,
    input wire logic test_mode_sel,
    input wire logic wide_frame_select,
    input wire logic bus_mode_select,
    input wire logic sep_strobe_sel,
    input wire logic cs_n,
    input wire logic strobe_or_read_pin,
    input wire logic dir_or_write_pin,
    input wire logic addr_latch_strobe,
    input wire logic [host_port_pkg::ADDR_W-1:0] dedicated_addr_lines,
    input wire logic [host_port_pkg::BYTE_W-1:0] low_addr_data_in,
    input wire logic [host_port_pkg::BYTE_W-1:0] upper_data_in,
    output logic [host_port_pkg::BYTE_W-1:0] low_addr_data_out,
    output logic low_addr_data_oe,
    output logic [host_port_pkg::BYTE_W-1:0] upper_data_out,
    output logic upper_data_oe,
    output logic transfer_ack_n,
    output logic transfer_ack_oe,
    input wire logic tx_drive_enable,
    input wire logic output_standby_bit,
    input wire logic [1:0] rate_sel,
    input wire logic [host_port_pkg::STREAMS-1:0] tx_data,
    output logic [host_port_pkg::STREAMS-1:0] serial_out_streams,
    output logic [host_port_pkg::STREAMS-1:0] serial_out_oe,
    output logic channel_control_out,
    output logic wide_frame_pulse_mode,
    output logic tap_in_reset
);
    import host_port_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [9:0] ctl_s;
    logic [ADDR_W+2*BYTE_W-1:0] bus_s;
    logic rst_n_s;
    logic cs_n_s;
    logic strobe_s;
    logic dir_s;
    logic als_s;
    logic mux_s;
    logic wfs_s;
    logic ode_s;
    logic tck_s;
    logic tms_s;
    logic [ADDR_W-1:0] ded_s;
    logic [BYTE_W-1:0] up_s;
    logic [BYTE_W-1:0] lo_s;

    sync2 #(
        .W(10),
        .RST_VAL(10'h3c1)
    ) u_sync_ctl (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .d({dev_rst_n, cs_n, strobe_or_read_pin, dir_or_write_pin,
            addr_latch_strobe, bus_mode_select, wide_frame_select,
            tx_drive_enable, test_clk, test_mode_sel}),
        .q(ctl_s)
    );

    sync2 #(
        .W(ADDR_W+2*BYTE_W),
        .RST_VAL('0)
    ) u_sync_bus (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .d({dedicated_addr_lines, upper_data_in, low_addr_data_in}),
        .q(bus_s)
    );

    assign {rst_n_s, cs_n_s, strobe_s, dir_s, als_s, mux_s, wfs_s,
            ode_s, tck_s, tms_s} = ctl_s;
    assign {ded_s, up_s, lo_s} = bus_s;

    ////////////////////////////////////////////////////////////////////
    // Test port

    tap_if tif ();
    logic tck_d_q;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            tck_d_q <= 1'b0;
        else
            tck_d_q <= tck_s;
    end

    assign tif.tck_rise = tck_s & ~tck_d_q;
    assign tif.tms = tms_s;
    assign tap_in_reset = tif.in_reset;

    tap_ctrl u_tap (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .test_rst_n(test_rst_n),
        .t(tif.ctrl)
    );

    ////////////////////////////////////////////////////////////////////
    // Device reset qualification

    logic [RCNT_W-1:0] rcnt_q;
    logic dev_rst_q;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rcnt_q <= '0;
        else if (rst_n_s)
            rcnt_q <= '0;
        else if (rcnt_q != RCNT_W'(RST_MIN_CYC))
            rcnt_q <= rcnt_q + 1'b1;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            dev_rst_q <= 1'b1;
        else if (rst_n_s)
            dev_rst_q <= 1'b0;
        else if (rcnt_q == RCNT_W'(RST_MIN_CYC - 1))
            dev_rst_q <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // Access decode

    logic sel;
    logic strobe;
    logic wr;
    logic active;
    logic [ADDR_W-1:0] addr_lat_q;
    logic [ADDR_W-1:0] addr;

    always_comb
    begin
        sel = ~cs_n_s;
        wr = ~dir_s;
        strobe = ~strobe_s;
        if (mux_s && sep_strobe_sel)
        begin
            strobe = ~strobe_s | ~dir_s;
        end
        else if (mux_s)
        begin
            strobe = strobe_s;
        end
        active = sel & strobe;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            addr_lat_q <= '0;
        else if (dev_rst_q)
            addr_lat_q <= '0;
        else if (mux_s && als_s)
            addr_lat_q <= lo_s;
    end

    assign addr = mux_s ? addr_lat_q : ded_s;

    ////////////////////////////////////////////////////////////////////
    // Control memory

    logic [DATA_W-1:0] mem [MEM_DEPTH];
    acc_state_t acc_q;
    logic start;

    assign start = (acc_q == ACC_IDLE) && active;

    always_ff @(posedge core_clk)
    begin
        if (start && wr && !dev_rst_q)
            mem[addr] <= {up_s, lo_s};
    end

    ////////////////////////////////////////////////////////////////////
    // Access sequencer

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            acc_q <= ACC_IDLE;
        else if (dev_rst_q)
            acc_q <= ACC_IDLE;
        else
        begin
            case (acc_q)
                ACC_IDLE: if (active) acc_q <= ACC_ACK;
                ACC_ACK: if (!active) acc_q <= ACC_HIGH;
                ACC_HIGH: acc_q <= ACC_IDLE;
                default: acc_q <= ACC_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            transfer_ack_n <= 1'b1;
            transfer_ack_oe <= 1'b0;
        end
        else if (dev_rst_q)
        begin
            transfer_ack_n <= 1'b1;
            transfer_ack_oe <= 1'b0;
        end
        else if (start)
        begin
            transfer_ack_n <= 1'b0;
            transfer_ack_oe <= 1'b1;
        end
        else if (acc_q == ACC_ACK && !active)
        begin
            transfer_ack_n <= 1'b1;
            transfer_ack_oe <= 1'b1;
        end
        else if (acc_q == ACC_HIGH)
        begin
            transfer_ack_n <= 1'b1;
            transfer_ack_oe <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            low_addr_data_out <= '0;
            upper_data_out <= '0;
            low_addr_data_oe <= 1'b0;
            upper_data_oe <= 1'b0;
        end
        else if (dev_rst_q || !active)
        begin
            low_addr_data_oe <= 1'b0;
            upper_data_oe <= 1'b0;
        end
        else if (start && !wr)
        begin
            {upper_data_out, low_addr_data_out} <= mem[addr];
            low_addr_data_oe <= 1'b1;
            upper_data_oe <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Frame position

    logic [IDX_W-1:0] idx_q;
    logic [SLOT_W-1:0] last_slot;
    logic [SLOT_W-1:0] slot;

    assign slot = idx_q[IDX_W-1:4];

    always_comb
    begin
        case (rate_sel)
            RATE_4M: last_slot = LAST_SLOT_4M;
            RATE_8M: last_slot = LAST_SLOT_8M;
            default: last_slot = LAST_SLOT_2M;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            idx_q <= '0;
        else if (dev_rst_q)
            idx_q <= '0;
        else if (slot >= last_slot && idx_q[3:0] == LAST_STREAM)
            idx_q <= '0;
        else
            idx_q <= idx_q + 1'b1;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            channel_control_out <= 1'b0;
        else if (dev_rst_q)
            channel_control_out <= 1'b0;
        else
            channel_control_out <= mem[idx_q[IDX_W-1:3]][CCO_LSB + 
                int'(idx_q[2:0])];
    end

    ////////////////////////////////////////////////////////////////////
    // Serial output drivers

    logic [STREAMS-1:0] hiz;

    assign hiz = {mem[{slot, 1'b1}][HIZ_LSB +: BYTE_W],
                  mem[{slot, 1'b0}][HIZ_LSB +: BYTE_W]};

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            serial_out_oe <= '0;
        else if (dev_rst_q)
            serial_out_oe <= '0;
        else if (!ode_s && !output_standby_bit)
            serial_out_oe <= '0;
        else
            serial_out_oe <= ~hiz;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            serial_out_streams <= '0;
        else if (dev_rst_q)
            serial_out_streams <= '0;
        else
            serial_out_streams <= tx_data;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            wide_frame_pulse_mode <= 1'b0;
        else
            wide_frame_pulse_mode <= wfs_s;
    end
endmodule

// ===== tb/host_cpu_model.sv
module host_cpu_model
(
    input wire logic core_clk,
    input wire logic bus_mode_select,
    input wire logic sep_strobe_sel,
    output logic cs_n,
    output logic strobe_or_read_pin,
    output logic dir_or_write_pin,
    output logic addr_latch_strobe,
    output logic [host_port_pkg::ADDR_W-1:0] dedicated_addr_lines,
    output logic [host_port_pkg::BYTE_W-1:0] low_addr_data_in,
    output logic [host_port_pkg::BYTE_W-1:0] upper_data_in,
    input wire logic [host_port_pkg::BYTE_W-1:0] low_addr_data_out,
    input wire logic low_addr_data_oe,
    input wire logic [host_port_pkg::BYTE_W-1:0] upper_data_out,
    input wire logic upper_data_oe,
    input wire logic transfer_ack_n,
    input wire logic transfer_ack_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    import host_port_pkg::*;
    logic act = 0, wr = 0, drv = 0, sel = 1;
    logic [15:0] lq = 16'h0;
    logic [7:0] aq = 8'h0;
    logic mux, sep, ack_w;
    assign mux = bus_mode_select;
    assign sep = mux && sep_strobe_sel;
    assign cs_n = !(act && sel);
    assign strobe_or_read_pin = sep ? !(act && !wr) : (mux ? act : !act);
    assign dir_or_write_pin = sep ? !(act && wr) : !wr;
    assign dedicated_addr_lines = (act && !mux) ? aq : ~aq;
    // Released lines show the inverse of the last value
    assign low_addr_data_in = low_addr_data_oe ? low_addr_data_out :
        (drv ? lq[7:0] : ~lq[7:0]);
    assign upper_data_in = upper_data_oe ? upper_data_out :
        (drv ? lq[15:8] : ~lq[15:8]);
    // Ack line has a pull-up
    assign ack_w = transfer_ack_oe ? transfer_ack_n : 1'b1;
    initial addr_latch_strobe = 0;

    task automatic xfer(input logic w, input logic c, input logic [7:0] a,
        input logic [15:0] d, output logic [15:0] rd, output logic got);
        got = 0;
        rd = 16'h0;
        wr = w;
        aq = a;
        sel = c;
        if (mux)
        begin
            lq[7:0] = a;
            drv = 1;
            addr_latch_strobe = 1;
            repeat (3) @(negedge core_clk);
            addr_latch_strobe = 0;
            repeat (3) @(negedge core_clk);
        end
        lq = d;
        drv = w;
        act = 1;
        for (int n = 0; n < 12 && !got; n++)
        begin
            @(posedge core_clk);
            if (ack_w === 1'b0)
            begin
                got = 1;
                rd = {upper_data_in, low_addr_data_in};
            end
        end
        @(negedge core_clk);
        act = 0;
        drv = 0;
        repeat (6) @(negedge core_clk);
    endtask
endmodule

// ===== tb/host_port_properties.sv
module host_port_properties
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic dev_rst_n,
    input wire logic test_rst_n,
    input wire logic wide_frame_select,
    input wire logic bus_mode_select,
    input wire logic sep_strobe_sel,
    input wire logic cs_n,
    input wire logic strobe_or_read_pin,
    input wire logic dir_or_write_pin,
    input wire logic low_addr_data_oe,
    input wire logic upper_data_oe,
    input wire logic transfer_ack_n,
    input wire logic transfer_ack_oe,
    input wire logic tx_drive_enable,
    input wire logic output_standby_bit,
    input wire logic [host_port_pkg::STREAMS-1:0] serial_out_oe,
    input wire logic wide_frame_pulse_mode,
    input wire logic tap_in_reset
);
    timeunit 1ns;
    timeprecision 1ns;
    import host_port_pkg::*;
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    a_ack_select:
    assert property ($rose(!transfer_ack_n && transfer_ack_oe) |->
        !$past(cs_n, 2) && !cs_n) else $error("ack without select");
    a_ack_release:
    assert property (transfer_ack_oe && !transfer_ack_n ##1 transfer_ack_n
        |-> transfer_ack_oe ##1 !transfer_ack_oe) else $error("ack release");
    a_idle_float:
    assert property (cs_n [*5] |-> !transfer_ack_oe && !low_addr_data_oe &&
        !upper_data_oe) else $error("drive while deselected");
    a_read_dir:
    assert property ($rose(low_addr_data_oe) |-> $past(dir_or_write_pin, 2)
        && dir_or_write_pin) else $error("drive on write");
    a_sep_read:
    assert property ($rose(low_addr_data_oe) && bus_mode_select &&
        sep_strobe_sel |-> !strobe_or_read_pin) else $error("read strobe");
    a_lanes_paired:
    assert property (low_addr_data_oe == upper_data_oe)
        else $error("lanes split");
    a_data_ack:
    assert property ($rose(low_addr_data_oe) |-> !transfer_ack_n &&
        transfer_ack_oe) else $error("data without ack");
    a_tap_reset:
    assert property (!test_rst_n |-> tap_in_reset) else $error("tap reset");
    a_frame_mode:
    assert property ($stable(wide_frame_select) [*4] |->
        wide_frame_pulse_mode == wide_frame_select) else $error("frame mode");
    a_standby_float:
    assert property ((!tx_drive_enable && !output_standby_bit) [*4] |->
        serial_out_oe == '0) else $error("streams driven");
    a_reset_float:
    assert property (!dev_rst_n [*8] |-> serial_out_oe == '0 &&
        !low_addr_data_oe && !transfer_ack_oe) else $error("reset drive");
endmodule

bind host_port_ctrl host_port_properties i_props (.*);

// ===== tb/switch_host_port_and_output_control_tb.sv
module switch_host_port_and_output_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import host_port_pkg::*;
    logic core_clk, sys_rst, dev_rst_n, test_rst_n, test_clk, test_mode_sel;
    logic wide_frame_select, bus_mode_select, sep_strobe_sel;
    logic tx_drive_enable, output_standby_bit;
    logic [1:0] rate_sel;
    logic [15:0] tx_data, serial_out_streams, serial_out_oe, rd;
    logic cs_n, strobe_or_read_pin, dir_or_write_pin, addr_latch_strobe;
    logic [7:0] dedicated_addr_lines, low_addr_data_in, upper_data_in;
    logic [7:0] low_addr_data_out, upper_data_out;
    logic low_addr_data_oe, upper_data_oe, transfer_ack_n, transfer_ack_oe;
    logic channel_control_out, wide_frame_pulse_mode, tap_in_reset, got;
    integer cco_exp, cco_n, f0, f1;
    int bad_count = 0;
    int checked = 0;

    host_port_ctrl i_dut (.*);
    host_cpu_model i_cpu (.*);

    initial
    begin
        core_clk = 0;
        forever #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [31:0] exp, seen);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic setmode(input int m);
        bus_mode_select = (m != 0);
        sep_strobe_sel = (m == 2);
        repeat (3) @(negedge core_clk);
    endtask

    function automatic logic [15:0] pat(input int a);
        return {(a == 6 || a == 200) ? 8'h05 : 8'h00, 8'(a) ^ 8'h5a};
    endfunction

    initial
    begin
        #(CLK_PERIOD_NS * 40000);
        bad_count++;
        complete_run();
    end

    initial
    begin
        sys_rst = 1;
        dev_rst_n = 1;
        test_rst_n = 0;
        test_clk = 0;
        test_mode_sel = 0;
        wide_frame_select = 0;
        {bus_mode_select, sep_strobe_sel} = 2'h0;
        {tx_drive_enable, output_standby_bit} = 2'h0;
        rate_sel = 2'h0;
        tx_data = 16'ha5a5;
        repeat (10) @(negedge core_clk);
        sys_rst = 0;
        test_rst_n = 1;
        repeat (4) @(negedge core_clk);
        // Every word written in one bus style, read in another
        for (int a = 0; a < 256; a++)
        begin
            setmode(a % 3);
            i_cpu.xfer(1'b1, 1'b1, 8'(a), pat(a), rd, got);
            check("write ack", 1, got);
            setmode((a + 1) % 3);
            i_cpu.xfer(1'b0, 1'b1, 8'(a), 16'h0, rd, got);
            check("read word", pat(a), rd);
        end
        i_cpu.xfer(1'b1, 1'b0, 8'h07, 16'hffff, rd, got);
        check("ack deselected", 0, got);
        i_cpu.xfer(1'b0, 1'b1, 8'h07, 16'h0, rd, got);
        check("word kept", pat(7), rd);
        for (int v = 1; v >= 0; v--)
        begin
            wide_frame_select = v[0];
            repeat (4) @(negedge core_clk);
            check("frame mode", v, wide_frame_pulse_mode);
        end
        repeat (2)
        begin
            test_clk = ~test_clk;
            repeat (3) @(negedge core_clk);
        end
        check("tap out of reset", 0, tap_in_reset);
        test_rst_n = 0;
        #1;
        check("tap reset", 1, tap_in_reset);
        @(negedge core_clk);
        test_rst_n = 1;
        tx_drive_enable = 1;
        for (int r = 0; r < 3; r++)
        begin
            rate_sel = 2'(r);
            repeat (2048) @(negedge core_clk);
            {cco_exp, cco_n, f0, f1} = '0;
            for (int a = 0; a < (64 << r); a++)
                cco_exp += $countones(8'(a) ^ 8'h5a);
            repeat (512 << r)
            begin
                @(negedge core_clk);
                cco_n += channel_control_out;
                f0 += !serial_out_oe[0];
                f1 += !serial_out_oe[1];
            end
            check("control bits", cco_exp, cco_n);
            check("float stream 0", (r == 2) ? 32 : 16, f0);
            check("float stream 1", 0, f1);
        end
        tx_drive_enable = 0;
        repeat (4) @(negedge core_clk);
        check("streams floated", 0, serial_out_oe);
        output_standby_bit = 1;
        repeat (4) @(negedge core_clk);
        check("standby drives", 1, serial_out_oe[1]);
        check("stream data", 16'ha5a5, serial_out_streams);
        output_standby_bit = 0;
        tx_drive_enable = 1;
        dev_rst_n = 0;
        repeat (8) @(negedge core_clk);
        check("reset floats", 0, serial_out_oe);
        check("reset stream data", 0, serial_out_streams);
        check("reset ack float", 0, transfer_ack_oe);
        check("reset data float", 0, low_addr_data_oe);
        dev_rst_n = 1;
        repeat (4) @(negedge core_clk);
        i_cpu.xfer(1'b0, 1'b1, 8'h10, 16'h0, rd, got);
        check("word after reset", pat(16), rd);
        complete_run();
    end
endmodule
